// *** include/poa_regs.vh ***
`ifndef POA_REGS_VH
`define POA_REGS_VH
// register indices; the byte address is four times the index
`define POA_IDX_C0L1_GRANT 10'h184
`define POA_IDX_C1L1_GRANT 10'h185
`define POA_IDX_C0L2_GRANT 10'h186
`define POA_IDX_C1L2_GRANT 10'h187
`define POA_IDX_CMD_STATE 10'h188
`define POA_IDX_CHK_STATE 10'h189
// grant reset values
`define POA_RST_C0L1_GRANT 12'h221
`define POA_RST_C1L1_GRANT 12'h442
`define POA_RST_C0L2_GRANT 12'h884
`define POA_RST_C1L2_GRANT 12'h118
// grant field layout
`define POA_GRANT_W 12
`define POA_HS_GRANT_LSB 0
`define POA_LS_GRANT_LSB 5
// output counts and control set widths
`define POA_NUM_CH 4
`define POA_NUM_LS 7
`define POA_NUM_HS 5
`define POA_FW_LS_FIRST 3
`define POA_THR_W 3
`define POA_LS_SET_W 6
`define POA_HS_SET_W 10
`define POA_SYNC_STAGES 2
`endif

// *** rtl/poa_merge.v ***
`timescale 1ns/1ps
`default_nettype none
// one merged control set; bit 0 of a set is the gate command
module poa_merge #(
   parameter W = 6
) (
   input wire pclk,
   input wire presetn,
   input wire [3:0] req,
   input wire [3:0] grant,
   input wire [3:0] unlocked,
   input wire [4*W-1:0] req_set,
   output wire [W-1:0] set_out
);
   reg [W-1:0] set_r;
   reg [W-1:0] set_nxt;
   integer c;

   always @* begin
      set_nxt = set_r;
      // index 0 is the highest priority channel, so it is scanned last
      for (c = 3; c >= 0; c = c - 1) begin
         if (req[c] && grant[c]) begin
            set_nxt = req_set[c*W +: W];
         end
      end
      // an unlocked granted channel makes any switch-on a single pulse
      if ((|(grant & unlocked)) && set_r[0]) begin
         set_nxt[0] = 1'b0;
      end
   end

   // without a granted request the set holds, except bit 0 under an unlocked granted channel, so arrivals apply in turn
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         set_r <= {W{1'b0}};
      end else begin
         set_r <= set_nxt;
      end
   end

   assign set_out = set_r;
endmodule // poa_merge
`default_nettype wire

// *** rtl/poa_sync.v ***
`timescale 1ns/1ps
`default_nettype none
module poa_sync #(
   parameter W = 1
) (
   input wire pclk,
   input wire presetn,
   input wire [W-1:0] async_in,
   output wire [W-1:0] sync_out
);
   reg [W-1:0] meta_r;
   reg [W-1:0] sync_r;

   // meta_r is read by sync_r only
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r <= {W{1'b0}};
         sync_r <= {W{1'b0}};
      end else begin
         meta_r <= async_in;
         sync_r <= meta_r;
      end
   end

   assign sync_out = sync_r;
endmodule // poa_sync
`default_nettype wire

// *** rtl/poa_top.v ***
// Our own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "poa_regs.vh"
module poa_top (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output wire [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire [3:0] core_unlocked,
   input wire [27:0] ch_ls_req,
   input wire [27:0] ch_ls_cmd,
   input wire [83:0] ch_ls_vds_thr,
   input wire [27:0] ch_ls_vds_chk,
   input wire [15:0] ch_ls_fw,
   input wire [19:0] ch_hs_req,
   input wire [19:0] ch_hs_cmd,
   input wire [59:0] ch_hs_vds_thr,
   input wire [59:0] ch_hs_src_thr,
   input wire [19:0] ch_hs_vds_chk,
   input wire [19:0] ch_hs_src_chk,
   input wire [3:0] ch_hs_fw,
   input wire [6:0] ls_vds_fbk,
   input wire [4:0] hs_vds_fbk,
   input wire [4:0] hs_src_fbk,
   output wire [6:0] ls_cmd,
   output wire [20:0] ls_vds_thr,
   output wire [6:0] ls_vds_chk,
   output wire [3:0] ls_fw,
   output wire [4:0] hs_cmd,
   output wire [14:0] hs_vds_thr,
   output wire [14:0] hs_src_thr,
   output wire [4:0] hs_vds_chk,
   output wire [4:0] hs_src_chk,
   output wire hs_fw,
   output wire [6:0] ls_vds_err,
   output wire [4:0] hs_vds_err,
   output wire [4:0] hs_src_err
);
   // channel order inside every vector: 0 core0_lane1, 1 core1_lane1,
   // 2 core0_lane2, 3 core1_lane2
   reg [`POA_GRANT_W-1:0] grant_r [0:3];
   reg [31:0] prdata_r;
   reg pready_r;
   reg pslverr_r;
   reg [31:0] rd_nxt;
   reg [6:0] ls_vds_err_r;
   reg [4:0] hs_vds_err_r;
   reg [4:0] hs_src_err_r;
   wire [6:0] ls_vds_fbk_s;
   wire [4:0] hs_vds_fbk_s;
   wire [4:0] hs_src_fbk_s;
   wire [7*`POA_LS_SET_W-1:0] ls_set;
   wire [5*`POA_HS_SET_W-1:0] hs_set;
   wire [3:0] dec;
   wire [1:0] widx;
   wire grant_wr;
   wire wr_go;
   wire setup;
   integer k;

   // {hit, index} for an APB byte address; six words are mapped
   function [3:0] poa_decode;
      input [11:0] addr;
      begin
         case (addr[11:2])
            `POA_IDX_C0L1_GRANT: poa_decode = 4'h8;
            `POA_IDX_C1L1_GRANT: poa_decode = 4'h9;
            `POA_IDX_C0L2_GRANT: poa_decode = 4'ha;
            `POA_IDX_C1L2_GRANT: poa_decode = 4'hb;
            `POA_IDX_CMD_STATE: poa_decode = 4'hc;
            `POA_IDX_CHK_STATE: poa_decode = 4'hd;
            default: poa_decode = 4'h0;
         endcase
      end
   endfunction

   // one status word: low-side field, high-side field, upper field
   function [31:0] poa_status;
      input [6:0] ls;
      input [4:0] hs;
      input [4:0] hi;
      begin
         poa_status = 32'h0000_0000;
         poa_status[11:5] = ls;
         poa_status[4:0] = hs;
         poa_status[20:16] = hi;
      end
   endfunction

   // 1 when the comparator level matches the command: an incoherent pair
   function poa_chk;
      input en;
      input cmd;
      input fbk;
      begin
         poa_chk = en && (cmd == fbk);
      end
   endfunction

   assign setup = psel && !penable;
   // pready goes high in the first access cycle: one access cycle per transfer
   assign wr_go = psel && penable && pready_r && pwrite;
   assign dec = poa_decode(paddr);
   assign widx = paddr[3:2];
   // codes 8 to b are the grant words; status words ignore writes
   assign grant_wr = wr_go && (dec[3:2] == 2'b10);

   always @* begin
      rd_nxt = 32'h0000_0000;
      case (dec)
         4'h8, 4'h9, 4'ha, 4'hb: begin
            // upper bits stay zero
            rd_nxt[`POA_GRANT_W-1:0] = grant_r[widx];
         end
         4'hc: begin
            rd_nxt = poa_status(ls_cmd, hs_cmd, {1'b0, core_unlocked});
         end
         4'hd: begin
            rd_nxt = poa_status(ls_vds_err_r, hs_vds_err_r, hs_src_err_r);
         end
         default: begin
            rd_nxt = 32'h0000_0000;
         end
      endcase
   end

   // every answer stands for the access cycle only
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
      end else begin
         pready_r <= setup;
      end
   end

   // pslverr falls with pready so a stale error never meets a new request
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr_r <= 1'b0;
      end else begin
         pslverr_r <= setup && !dec[3];
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0000_0000;
      end else if (setup && !pwrite) begin
         prdata_r <= rd_nxt;
      end else begin
         prdata_r <= 32'h0000_0000;
      end
   end

   // grant registers; status words ignore writes
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         grant_r[0] <= `POA_RST_C0L1_GRANT;
         grant_r[1] <= `POA_RST_C1L1_GRANT;
         grant_r[2] <= `POA_RST_C0L2_GRANT;
         grant_r[3] <= `POA_RST_C1L2_GRANT;
      end else if (grant_wr) begin
         if (pstrb[0]) begin
            grant_r[widx][7:0] <= pwdata[7:0];
         end
         if (pstrb[1]) begin
            grant_r[widx][11:8] <= pwdata[11:8];
         end
      end
   end

   poa_sync #(
      .W(17)
   ) u_fbk_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in({hs_src_fbk, hs_vds_fbk, ls_vds_fbk}),
      .sync_out({hs_src_fbk_s, hs_vds_fbk_s, ls_vds_fbk_s})
   );

   genvar i;
   genvar c;
   generate
      for (i = 0; i < `POA_NUM_LS; i = i + 1) begin : g_ls
         wire [4*`POA_LS_SET_W-1:0] req_set;
         wire [3:0] req;
         wire [3:0] grant;
         for (c = 0; c < `POA_NUM_CH; c = c + 1) begin : g_ch
            wire fw;
            if (i >= `POA_FW_LS_FIRST) begin : g_fw
               assign fw = ch_ls_fw[c*4 + i - `POA_FW_LS_FIRST];
            end else begin : g_nofw
               assign fw = 1'b0;
            end
            // set = {fw, check enable, threshold, command}
            assign req_set[c*`POA_LS_SET_W +: `POA_LS_SET_W] = {fw,
               ch_ls_vds_chk[c*7+i], ch_ls_vds_thr[c*21+i*3 +: 3],
               ch_ls_cmd[c*7+i]};
            assign req[c] = ch_ls_req[c*7+i];
            assign grant[c] = grant_r[c][`POA_LS_GRANT_LSB+i];
         end
         poa_merge #(
            .W(`POA_LS_SET_W)
         ) u_merge (
            .pclk(pclk),
            .presetn(presetn),
            .req(req),
            .grant(grant),
            .unlocked(core_unlocked),
            .req_set(req_set),
            .set_out(ls_set[i*`POA_LS_SET_W +: `POA_LS_SET_W])
         );
         assign ls_cmd[i] = ls_set[i*`POA_LS_SET_W];
         assign ls_vds_thr[i*3 +: 3] = ls_set[i*`POA_LS_SET_W+1 +: 3];
         assign ls_vds_chk[i] = ls_set[i*`POA_LS_SET_W+4];
         if (i >= `POA_FW_LS_FIRST) begin : g_fwo
            assign ls_fw[i-`POA_FW_LS_FIRST] = ls_set[i*`POA_LS_SET_W+5];
         end
      end

      for (i = 0; i < `POA_NUM_HS; i = i + 1) begin : g_hs
         wire [4*`POA_HS_SET_W-1:0] req_set;
         wire [3:0] req;
         wire [3:0] grant;
         for (c = 0; c < `POA_NUM_CH; c = c + 1) begin : g_ch
            wire fw;
            if (i == `POA_NUM_HS-1) begin : g_fw
               assign fw = ch_hs_fw[c];
            end else begin : g_nofw
               assign fw = 1'b0;
            end
            // set = {fw, src check, vds check, src thr, vds thr, command}
            assign req_set[c*`POA_HS_SET_W +: `POA_HS_SET_W] = {fw,
               ch_hs_src_chk[c*5+i], ch_hs_vds_chk[c*5+i],
               ch_hs_src_thr[c*15+i*3 +: 3], ch_hs_vds_thr[c*15+i*3 +: 3],
               ch_hs_cmd[c*5+i]};
            assign req[c] = ch_hs_req[c*5+i];
            assign grant[c] = grant_r[c][`POA_HS_GRANT_LSB+i];
         end
         poa_merge #(
            .W(`POA_HS_SET_W)
         ) u_merge (
            .pclk(pclk),
            .presetn(presetn),
            .req(req),
            .grant(grant),
            .unlocked(core_unlocked),
            .req_set(req_set),
            .set_out(hs_set[i*`POA_HS_SET_W +: `POA_HS_SET_W])
         );
         assign hs_cmd[i] = hs_set[i*`POA_HS_SET_W];
         assign hs_vds_thr[i*3 +: 3] = hs_set[i*`POA_HS_SET_W+1 +: 3];
         assign hs_src_thr[i*3 +: 3] = hs_set[i*`POA_HS_SET_W+4 +: 3];
         assign hs_vds_chk[i] = hs_set[i*`POA_HS_SET_W+7];
         assign hs_src_chk[i] = hs_set[i*`POA_HS_SET_W+8];
      end
   endgenerate

   assign hs_fw = hs_set[4*`POA_HS_SET_W+9];

   // a driven-on output should see a low comparator and vice versa;
   // the check is raw, filtering and blanking are done downstream
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ls_vds_err_r <= 7'h00;
         hs_vds_err_r <= 5'h00;
         hs_src_err_r <= 5'h00;
      end else begin
         for (k = 0; k < `POA_NUM_LS; k = k + 1) begin
            ls_vds_err_r[k] <= poa_chk(ls_vds_chk[k], ls_cmd[k],
               ls_vds_fbk_s[k]);
         end
         for (k = 0; k < `POA_NUM_HS; k = k + 1) begin
            hs_vds_err_r[k] <= poa_chk(hs_vds_chk[k], hs_cmd[k],
               hs_vds_fbk_s[k]);
            hs_src_err_r[k] <= poa_chk(hs_src_chk[k], hs_cmd[k],
               hs_src_fbk_s[k]);
         end
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign ls_vds_err = ls_vds_err_r;
   assign hs_vds_err = hs_vds_err_r;
   assign hs_src_err = hs_src_err_r;
endmodule // poa_top
`default_nettype wire

// *** verification/poa_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module poa_core_model (
   input wire logic pclk,
   output logic [27:0] ch_ls_req,
   output logic [19:0] ch_hs_req,
   output logic [339:0] ch_data
);
   logic [27:0] ls_pend = 28'h0;
   logic [19:0] hs_pend = 20'h0;
   logic [351:0] r;
   integer seed = 14490;
   initial {ch_ls_req, ch_hs_req, ch_data} = '0;
   // data churns every cycle so a design that samples it off-request fails
   always @(posedge pclk) begin
      for (int k = 0; k < 11; k++) r[k*32+:32] = $random(seed);
      ch_data <= r[339:0];
      ch_ls_req <= ls_pend;
      ch_hs_req <= hs_pend;
      ls_pend = 28'h0;
      hs_pend = 20'h0;
   end
endmodule // poa_core_model
`default_nettype wire

// *** verification/poa_top_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module poa_top_asserts (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [3:0] core_unlocked,
   input wire logic [27:0] ch_ls_req,
   input wire logic [19:0] ch_hs_req,
   input wire logic [6:0] ls_vds_fbk,
   input wire logic [6:0] ls_cmd,
   input wire logic [6:0] ls_vds_chk,
   input wire logic [6:0] ls_vds_err,
   input wire logic [4:0] hs_vds_fbk,
   input wire logic [4:0] hs_vds_chk,
   input wire logic [4:0] hs_vds_err,
   input wire logic [4:0] hs_cmd,
   input wire logic [4:0] hs_src_chk,
   input wire logic [4:0] hs_src_err
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence setup_s; psel && !penable; endsequence
   sequence fbk_settled; $stable(ls_vds_fbk)[*3]; endsequence
   sequence hs_fbk_settled; $stable(hs_vds_fbk)[*3]; endsequence
   sequence quiet_s;
      ch_ls_req == 28'h0 && ch_hs_req == 20'h0 && core_unlocked == 4'h0;
   endsequence
   AST_READY_AFTER_SETUP: assert property (setup_s |=> pready)
      else $error("no ready after setup");
   AST_READY_ONE: assert property (pready |=> !pready)
      else $error("ready held too long");
   AST_RSV_ZERO: assert property (pready && paddr[11:4] == 8'h61
      |-> prdata[31:12] == 20'h0) else $error("upper read bits set");
   AST_ERR_DATA: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("error response carries data");
   AST_LS_HOLD: assert property (quiet_s |=> $stable(ls_cmd))
      else $error("low-side command moved without request");
   AST_HS_HOLD: assert property (quiet_s |=> $stable(hs_cmd))
      else $error("high-side command moved without request");
   AST_LS_FORCE: assert property (core_unlocked == 4'hf |=>
      (ls_cmd & $past(ls_cmd)) == 7'h0) else $error("low-side on too long");
   AST_HS_FORCE: assert property (core_unlocked == 4'hf |=>
      (hs_cmd & $past(hs_cmd)) == 5'h0) else $error("high-side on too long");
   AST_CHK_OFF: assert property (!(|{ls_vds_chk, hs_src_chk}) |=>
      {ls_vds_err, hs_src_err} == 12'h0) else $error("error flagged");
   AST_CHK_VAL: assert property (fbk_settled |=> ls_vds_err ==
      $past(ls_vds_chk & ~(ls_cmd ^ ls_vds_fbk))) else $error("bad check");
   AST_HS_VDS_VAL: assert property (hs_fbk_settled |=> hs_vds_err ==
      $past(hs_vds_chk & ~(hs_cmd ^ hs_vds_fbk))) else $error("bad hs check");
endmodule // poa_top_asserts
bind poa_top poa_top_asserts poa_top_asserts_i (.pclk, .presetn, .psel,
   .penable, .paddr, .prdata, .pready, .pslverr, .core_unlocked, .ch_ls_req,
   .hs_vds_fbk, .hs_vds_chk, .hs_vds_err,
   .ch_hs_req, .ls_vds_fbk, .ls_cmd, .ls_vds_chk, .ls_vds_err, .hs_cmd,
   .hs_src_chk, .hs_src_err);
`default_nettype wire

// *** verification/predriver_output_access_arbiter_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "poa_regs.vh"
module predriver_output_access_arbiter_test;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, q;
   logic [3:0] unl = 0;
   logic [16:0] fb = 0;
   logic [84:0] ex = '0;
   logic [11:0] g [4];
   logic [11:0] rst [4] = '{`POA_RST_C0L1_GRANT, `POA_RST_C1L1_GRANT,
      `POA_RST_C0L2_GRANT, `POA_RST_C1L2_GRANT};
   int errors = 0, tests_run = 0;
   integer seed = 14490;
   wire logic [31:0] prdata;
   wire logic pready, pslverr;
   wire logic [27:0] lr;
   wire logic [19:0] hr;
   wire logic [339:0] d;
   wire logic [84:0] mo;
   poa_core_model poa_core_model_i (.pclk(pclk), .ch_ls_req(lr),
      .ch_hs_req(hr), .ch_data(d));
   poa_top poa_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr,
      .core_unlocked(unl), .ch_ls_req(lr), .ch_hs_req(hr),
      .ch_ls_cmd(d[27:0]), .ch_ls_vds_thr(d[111:28]),
      .ch_ls_vds_chk(d[139:112]), .ch_ls_fw(d[155:140]),
      .ch_hs_cmd(d[175:156]), .ch_hs_vds_thr(d[235:176]),
      .ch_hs_src_thr(d[295:236]), .ch_hs_vds_chk(d[315:296]),
      .ch_hs_src_chk(d[335:316]), .ch_hs_fw(d[339:336]),
      .ls_vds_fbk(fb[16:10]), .hs_vds_fbk(fb[9:5]), .hs_src_fbk(fb[4:0]),
      .ls_cmd(mo[84:78]), .ls_vds_thr(mo[77:57]), .ls_vds_chk(mo[56:50]),
      .ls_fw(mo[49:46]), .hs_cmd(mo[45:41]), .hs_vds_thr(mo[40:26]),
      .hs_src_thr(mo[25:11]), .hs_vds_chk(mo[10:6]),
      .hs_src_chk(mo[5:1]), .hs_fw(mo[0]), .ls_vds_err(), .hs_vds_err(),
      .hs_src_err());
   initial forever #25 pclk = ~pclk;
   function automatic int win(input logic [3:0] m);
      for (int k = 0; k < 4; k++) if (m[k]) return k;
      return 4;
   endfunction
   function automatic logic [11:0] ga(input int c);
      return {`POA_IDX_C0L1_GRANT, 2'b00} + 12'(c * 4);
   endfunction
   task check(input logic [84:0] seen, input logic [84:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
            output logic [31:0] rd, output logic er);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, wd};
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   // requests land every third cycle; the expectation reads the very
   // values the design samples, at the same edge, before they churn
   task fire(input logic [27:0] lm, input logic [19:0] hm);
      logic [3:0] m;
      int c;
      @(negedge pclk);
      poa_core_model_i.ls_pend = lm;
      poa_core_model_i.hs_pend = hm;
      repeat (2) @(posedge pclk);
      for (int i = 0; i < 7; i++) begin
         for (int k = 0; k < 4; k++) m[k] = g[k][5+i] & lr[k*7+i];
         c = win(m);
         if (c < 4) begin
            ex[78+i] = d[c*7+i];
            ex[57+i*3+:3] = d[28+c*21+i*3+:3];
            ex[50+i] = d[112+c*7+i];
            if (i > 2) ex[43+i] = d[137+c*4+i];
         end
      end
      for (int i = 0; i < 5; i++) begin
         for (int k = 0; k < 4; k++) m[k] = g[k][i] & hr[k*5+i];
         c = win(m);
         if (c < 4) begin
            ex[41+i] = d[156+c*5+i];
            ex[26+i*3+:3] = d[176+c*15+i*3+:3];
            ex[11+i*3+:3] = d[236+c*15+i*3+:3];
            ex[6+i] = d[296+c*5+i];
            ex[1+i] = d[316+c*5+i];
            if (i == 4) ex[0] = d[336+c];
         end
      end
      @(negedge pclk);
      check(mo, ex);
   endtask
   task force_off;
      ex[84:78] &= ~(g[0][11:5] | g[1][11:5] | g[2][11:5] | g[3][11:5]);
      ex[45:41] &= ~(g[0][4:0] | g[1][4:0] | g[2][4:0] | g[3][4:0]);
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      #100000;
      errors++;
      end_sim();
   end
   initial begin
      logic [31:0] w;
      logic er;
      repeat (16) @(posedge pclk);
      presetn <= 1;
      for (int c = 0; c < 4; c++) begin
         apb(0, ga(c), 0, q, er);
         check(85'(q), 85'(rst[c]));
         w = $random(seed);
         apb(1, ga(c), w, q, er);
         apb(0, ga(c), 0, q, er);
         check(85'(q), 85'(w[11:0]));
         g[c] = w[11:0];
      end
      apb(0, 12'h7fc, 0, q, er);
      check(85'({er, q}), 85'(33'h100000000));
      $display("test registers done");
      for (int n = 0; n < 300; n++) begin
         @(posedge pclk);
         fb <= 17'($random(seed));
         fire(n % 8 ? 28'($random(seed)) : '1,
            n % 8 ? 20'($random(seed)) : '1);
      end
      apb(0, ga(5), 0, q, er);
      check(85'(q), 85'({ex[5:1] & ~(ex[45:41] ^ fb[4:0]), 4'h0,
         ex[56:50] & ~(ex[84:78] ^ fb[16:10]),
         ex[10:6] & ~(ex[45:41] ^ fb[9:5])}));
      apb(0, ga(4), 0, q, er);
      check(85'(q), 85'({ex[84:78], ex[45:41]}));
      $display("test arbitration done");
      // every output needs a granted unlocked channel or nothing is forced
      apb(1, ga(3), 32'hfff, q, er);
      g[3] = 12'hfff;
      @(posedge pclk);
      unl <= 4'hf;
      repeat (2) @(posedge pclk);
      force_off();
      fire('1, '1);
      @(posedge pclk);
      force_off();
      @(negedge pclk);
      check(mo, ex);
      apb(0, ga(4), 0, q, er);
      check(85'(q), 85'(32'h000f_0000));
      @(posedge pclk);
      unl <= 4'h0;
      $display("test unlocked done");
      end_sim();
   end
endmodule // predriver_output_access_arbiter_test
`default_nettype wire
